// file: logic/servo_autotune_params.svh
// Purpose: constants for the real-time tuning control block
// Assumes: 20 MHz clk, byte addressed Avalon-MM slave
// Notes: definitions only
//
// Functional notes
// RULE_01: mode settings 1..6 enable tuning; factory default load sets setting to 1.
// RULE_02: a new mode setting takes effect only at power-on or drive-enable rise.
// RULE_03: latched mode 0 disables tuning; any value except 0 and 7 enables it.
// RULE_04: adaptive filter runs only while control mode select equals 2.
// RULE_05: tuning works in every control mode when the mode setting enables it.
// RULE_06: while tuning, gains, filters and inertia ratio are updated automatically.
// RULE_07: while tuning, the second gain action setup is forced to 1.
// RULE_08: while tuning, external writes to the tuned parameter set are rejected.
// RULE_09: inertia ratio and filter frequency are saved to nvm every 30 minutes.
// RULE_10: after power-on, tuning starts from the nvm inertia and filter values.
// RULE_11: holding the up key 5 s grows bars, then shows start, done or error.
// RULE_12: operator should pick modes 3 or 6 for varying inertia, lower stiffness.
`ifndef SERVO_AUTOTUNE_PARAMS_SVH
`define SERVO_AUTOTUNE_PARAMS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ          20000000
`define SAVE_PERIOD_MIN 30
`define SEC_PER_MIN     60
`define SAVE_CYCLES_DEF (64'(`SAVE_PERIOD_MIN) * 64'(`SEC_PER_MIN) * 64'(`CLK_HZ))
`define KEY_HOLD_SEC    5
`define HOLD_CYCLES_DEF (`KEY_HOLD_SEC * `CLK_HZ)
`define BAR_MAX         3'h5

// ****************************************************************
// register map (byte offsets)
// ****************************************************************
`define OFS_CTRL  8'h00
`define OFS_CMD   8'h04
`define OFS_STAT  8'h08
`define OFS_IRQ   8'h0C
`define OFS_MASK  8'h10
`define OFS_PAR   8'h20
`define OFS_PEND  8'h48

// ctrl fields
`define CTRL_MODE_LSB  0
`define CTRL_CTL_LSB   8
`define CTRL_STIF_LSB  16
// cmd bits
`define CMD_DEFAULT 0
`define CMD_SAVE    1
// status fields
`define STAT_TUNE_BIT 4
`define STAT_FILT_BIT 5
`define STAT_BAR_LSB  8
`define STAT_CON_LSB  12
// irq bits
`define IRQ_W     4
`define IRQ_REJ   0
`define IRQ_DONE  1
`define IRQ_ERR   2
`define IRQ_LATCH 3

// ****************************************************************
// parameter table and values
// ****************************************************************
`define NPAR        11
`define IDX_FIRST   4'h0
`define IDX_INERTIA 4'h8
`define IDX_GAIN2   4'h9
`define IDX_FILT    4'hA
`define MODE_DEF    3'h1
`define MODE_OFF    3'h0
`define MODE_RSVD   3'h7
`define CTL_HIPOS   4'h2
`define STIF_DEF    4'h4
`define GAIN2_FIXED 16'h0001
`define PAR_RST     16'h0000

`endif

// file: logic/servo_autotune_pkg.sv
// Purpose: types shared by the tuning control block
// Assumes: nothing
// Notes: constants live in servo_autotune_params.svh
package servo_autotune_pkg;
	typedef enum logic [2:0] {CON_IDLE, CON_HOLD, CON_START, CON_BUSY,
		CON_DONE, CON_ERR} console_t;
	typedef enum logic [1:0] {SV_IDLE, SV_REQ, SV_WAIT} saver_t;
endpackage : servo_autotune_pkg

// file: logic/sync_2ff.sv
// Purpose: two flop synchroniser for a pin level
// Assumes: rstN already synchronous to clk
// Notes: first stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module sync_2ff (
	input  wire logic clk,
	input  wire logic rstN,
	input  wire logic pinIn,
	output logic      syncOut
);
	logic meta_r;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			meta_r  <= 1'b0;
			syncOut <= 1'b0;
		end else begin
			meta_r  <= pinIn;
			syncOut <= meta_r;
		end
	end
endmodule : sync_2ff
`default_nettype wire

// file: logic/save_sequencer.sv
// Purpose: writes a list of parameters to nvm, one handshake per word
// Assumes: nvm holds ack high for one cycle per accepted word
// Notes: short list is inertia then filter frequency; long list is all
`timescale 1ns/1ns
`default_nettype none
`include "servo_autotune_params.svh"
module save_sequencer (
	input  wire logic        clk,
	input  wire logic        rstN,
	input  wire logic        start,
	input  wire logic        saveAll,
	input  wire logic [15:0] parData,
	output logic      [3:0]  parIdx,
	output logic             nvmWrReq,
	output logic      [3:0]  nvmAddr,
	output logic      [15:0] nvmData,
	input  wire logic        nvmAck,
	input  wire logic        nvmErr,
	output logic             busy,
	output logic             done,
	output logic             err
);
	servo_autotune_pkg::saver_t state_r, state_nxt;
	logic        all_r, all_nxt, errAcc_r, errAcc_nxt;
	logic [3:0]  idx_r, idx_nxt, addr_nxt;
	logic [15:0] data_nxt;
	logic        req_nxt, done_nxt, err_nxt;

	assign parIdx = idx_r;
	assign busy   = (state_r != servo_autotune_pkg::SV_IDLE);

	always_comb begin
		state_nxt = state_r;
		all_nxt = all_r;
		errAcc_nxt = errAcc_r;
		idx_nxt = idx_r;
		addr_nxt = nvmAddr;
		data_nxt = nvmData;
		req_nxt = nvmWrReq;
		done_nxt = 1'b0;
		err_nxt = 1'b0;
		case (state_r)
			servo_autotune_pkg::SV_IDLE: begin
				if (start) begin
					all_nxt = saveAll;
					errAcc_nxt = 1'b0;
					idx_nxt = saveAll ? `IDX_FIRST : `IDX_INERTIA;
					state_nxt = servo_autotune_pkg::SV_REQ;
				end
			end
			servo_autotune_pkg::SV_REQ: begin
				// data sampled here so a later estimator update cannot tear it
				addr_nxt = idx_r;
				data_nxt = parData;
				req_nxt = 1'b1;
				state_nxt = servo_autotune_pkg::SV_WAIT;
			end
			servo_autotune_pkg::SV_WAIT: begin
				if (nvmAck) begin
					req_nxt = 1'b0;
					errAcc_nxt = errAcc_r | nvmErr;
					if (idx_r == `IDX_FILT) begin
						done_nxt = !(errAcc_r | nvmErr);
						err_nxt = errAcc_r | nvmErr;
						state_nxt = servo_autotune_pkg::SV_IDLE;
					end else begin
						idx_nxt = all_r ? idx_r + 4'h1 : `IDX_FILT;
						state_nxt = servo_autotune_pkg::SV_REQ;
					end
				end
			end
			default: state_nxt = servo_autotune_pkg::SV_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state_r <= servo_autotune_pkg::SV_IDLE;
			all_r <= 1'b0;
			errAcc_r <= 1'b0;
			idx_r <= `IDX_FIRST;
			nvmAddr <= `IDX_FIRST;
			nvmData <= `PAR_RST;
			nvmWrReq <= 1'b0;
			done <= 1'b0;
			err <= 1'b0;
		end else begin
			state_r <= state_nxt;
			all_r <= all_nxt;
			errAcc_r <= errAcc_nxt;
			idx_r <= idx_nxt;
			nvmAddr <= addr_nxt;
			nvmData <= data_nxt;
			nvmWrReq <= req_nxt;
			done <= done_nxt;
			err <= err_nxt;
		end
	end
endmodule : save_sequencer
`default_nettype wire

// file: logic/servo_autotune_control.sv
// Purpose: tuning mode latch, parameter lock, periodic and console saves
// Assumes: estimator and nvm on clk; driveEn and upKey are pins
// Notes: registers over Avalon-MM, one wait state per access
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "servo_autotune_params.svh"
module servo_autotune_control #(
	parameter logic [63:0] SAVE_CYCLES = `SAVE_CYCLES_DEF,
	parameter logic [31:0] HOLD_CYCLES = `HOLD_CYCLES_DEF
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic             irq,
	input  wire logic        driveEn,
	input  wire logic        upKey,
	input  wire logic        estValid,
	input  wire logic [3:0]  estSel,
	input  wire logic [15:0] estData,
	input  wire logic [15:0] nvmInitInertia,
	input  wire logic [15:0] nvmInitFilter,
	output logic             nvmWrReq,
	output logic      [3:0]  nvmAddr,
	output logic      [15:0] nvmData,
	input  wire logic        nvmAck,
	input  wire logic        nvmErr,
	output logic             tuneOn,
	output logic             filterOn,
	output logic      [2:0]  barCount,
	output logic      [2:0]  consState
);
	// ****************************************************************
	// reset release and pin synchronisers
	// ****************************************************************
	logic rstMeta_r, rstN;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_r <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstN <= rstMeta_r;
		end
	end

	logic drvSync, keySync, drvPrev_r, booted_r;
	sync_2ff uDrv (.clk(clk), .rstN(rstN), .pinIn(driveEn), .syncOut(drvSync));
	sync_2ff uKey (.clk(clk), .rstN(rstN), .pinIn(upKey), .syncOut(keySync));

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [2:0]  modeSet_r, modeSet_nxt, modeLat_r, modeLat_nxt;
	logic [3:0]  ctlMode_r, ctlMode_nxt, stiff_r, stiff_nxt;
	logic [15:0] par_r [`NPAR];
	logic [15:0] par_nxt [`NPAR];
	logic [`IRQ_W-1:0] irqSt_r, irqSt_nxt, mask_r, mask_nxt, ev;
	logic [31:0] rd_nxt;
	logic        wait_nxt, tune_nxt, filt_nxt, latchEv, accept, wrAcc;
	logic        busSave, saveStart, saveAll, svBusy, svDone, svErr;
	logic [3:0]  svIdx, wIdx;
	logic        inTable;
	logic [63:0] tmr_r, tmr_nxt;
	logic        tmrHit, pend_r, pend_nxt;

	assign latchEv = !booted_r || (drvSync && !drvPrev_r); // RULE_02
	assign accept  = (read || write) && waitrequest;
	assign wrAcc   = write && !waitrequest;
	assign inTable = address >= `OFS_PAR && address <= `OFS_PEND
		&& address[1:0] == 2'b00;
	assign wIdx    = 4'((address - `OFS_PAR) >> 2);

	// ****************************************************************
	// mode latch, parameters and bus registers
	// ****************************************************************
	always_comb begin
		modeSet_nxt = modeSet_r;
		ctlMode_nxt = ctlMode_r;
		stiff_nxt = stiff_r;
		mask_nxt = mask_r;
		par_nxt = par_r;
		ev = '0;
		ev[`IRQ_DONE] = svDone;
		ev[`IRQ_ERR] = svErr;
		busSave = 1'b0;
		wait_nxt = !accept;
		rd_nxt = readdata;
		modeLat_nxt = latchEv ? modeSet_r : modeLat_r; // RULE_02
		ev[`IRQ_LATCH] = latchEv && booted_r;
		if (wrAcc) begin
			case (address)
				`OFS_CTRL: begin
					modeSet_nxt = writedata[`CTRL_MODE_LSB +: 3];
					ctlMode_nxt = writedata[`CTRL_CTL_LSB +: 4];
					stiff_nxt = writedata[`CTRL_STIF_LSB +: 4];
				end
				`OFS_CMD: begin
					if (writedata[`CMD_DEFAULT])
						modeSet_nxt = `MODE_DEF; // RULE_01
					busSave = writedata[`CMD_SAVE];
				end
				`OFS_MASK: mask_nxt = writedata[`IRQ_W-1:0];
				default: begin
					if (inTable) begin
						if (tuneOn)
							ev[`IRQ_REJ] = 1'b1; // RULE_08
						else
							par_nxt[wIdx] = writedata[15:0];
					end
				end
			endcase
		end
		// estimator owns the tuned set only while tuning is on
		if (estValid && tuneOn && estSel <= `IDX_FILT && estSel != `IDX_GAIN2
			&& (estSel != `IDX_FILT || filterOn))
			par_nxt[estSel] = estData; // RULE_06 RULE_04
		if (tuneOn)
			par_nxt[`IDX_GAIN2] = `GAIN2_FIXED; // RULE_07
		if (!booted_r) begin
			par_nxt[`IDX_INERTIA] = nvmInitInertia; // RULE_10
			par_nxt[`IDX_FILT] = nvmInitFilter; // RULE_10
		end
		if (accept && read) begin
			case (address)
				`OFS_CTRL: rd_nxt = {12'h000, stiff_r, 4'h0, ctlMode_r,
					5'h00, modeSet_r};
				`OFS_STAT: rd_nxt = {17'h00000, consState, 1'b0, barCount,
					2'h0, filterOn, tuneOn, 1'b0, modeLat_r};
				`OFS_IRQ:  rd_nxt = {28'h0000000, irqSt_r};
				`OFS_MASK: rd_nxt = {28'h0000000, mask_r};
				default:   rd_nxt = inTable ? {16'h0000, par_r[wIdx]} : '0;
			endcase
		end
		// mode 7 is reserved and treated as off; control mode does not matter
		tune_nxt = modeLat_nxt != `MODE_OFF && modeLat_nxt != `MODE_RSVD; // RULE_03 RULE_05 RULE_01
		filt_nxt = tune_nxt && ctlMode_nxt == `CTL_HIPOS; // RULE_04
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			modeSet_r <= `MODE_DEF;
			modeLat_r <= `MODE_OFF;
			ctlMode_r <= `CTL_HIPOS;
			stiff_r <= `STIF_DEF;
			mask_r <= '0;
			readdata <= '0;
			waitrequest <= 1'b1;
			tuneOn <= 1'b0;
			filterOn <= 1'b0;
			booted_r <= 1'b0;
			drvPrev_r <= 1'b0;
			for (int i = 0; i < `NPAR; i++) par_r[i] <= `PAR_RST;
		end else begin
			modeSet_r <= modeSet_nxt;
			modeLat_r <= modeLat_nxt;
			ctlMode_r <= ctlMode_nxt;
			stiff_r <= stiff_nxt;
			mask_r <= mask_nxt;
			readdata <= rd_nxt;
			waitrequest <= wait_nxt;
			tuneOn <= tune_nxt;
			filterOn <= filt_nxt;
			booted_r <= 1'b1;
			drvPrev_r <= drvSync;
			par_r <= par_nxt;
		end
	end

	// ****************************************************************
	// periodic save timer and save arbitration
	// ****************************************************************
	servo_autotune_pkg::console_t con_r, con_nxt;
	logic [31:0] hold_r, hold_nxt;
	logic [2:0]  bar_nxt;

	assign tmrHit = tmr_r >= SAVE_CYCLES - 64'h1;
	assign saveAll = (con_r == servo_autotune_pkg::CON_START) || busSave;
	// console and bus saves take priority; a periodic one waits in pend_r
	assign saveStart = !svBusy && (saveAll || pend_r);

	always_comb begin
		tmr_nxt = (tuneOn && !tmrHit) ? tmr_r + 64'h1 : 64'h0; // RULE_09
		pend_nxt = pend_r;
		if (tuneOn && tmrHit)
			pend_nxt = 1'b1; // RULE_09
		else if (saveStart && !saveAll)
			pend_nxt = 1'b0;
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			tmr_r <= '0;
			pend_r <= 1'b0;
		end else begin
			tmr_r <= tmr_nxt;
			pend_r <= pend_nxt;
		end
	end

	save_sequencer uSave (
		.clk(clk), .rstN(rstN), .start(saveStart), .saveAll(saveAll),
		.parData(par_r[svIdx]), .parIdx(svIdx), .nvmWrReq(nvmWrReq),
		.nvmAddr(nvmAddr), .nvmData(nvmData), .nvmAck(nvmAck),
		.nvmErr(nvmErr), .busy(svBusy), .done(svDone), .err(svErr)
	);

	// ****************************************************************
	// console key hold sequence
	// ****************************************************************
	always_comb begin
		con_nxt = con_r;
		hold_nxt = hold_r;
		bar_nxt = barCount;
		case (con_r)
			servo_autotune_pkg::CON_IDLE: begin
				hold_nxt = '0;
				bar_nxt = '0;
				if (keySync)
					con_nxt = servo_autotune_pkg::CON_HOLD;
			end
			servo_autotune_pkg::CON_HOLD: begin
				if (!keySync) begin
					con_nxt = servo_autotune_pkg::CON_IDLE;
				end else if (hold_r >= HOLD_CYCLES / 32'(`BAR_MAX) - 32'h1) begin
					hold_nxt = '0;
					bar_nxt = barCount + 3'h1; // RULE_11
					if (barCount + 3'h1 == `BAR_MAX)
						con_nxt = servo_autotune_pkg::CON_START;
				end else begin
					hold_nxt = hold_r + 32'h1;
				end
			end
			servo_autotune_pkg::CON_START: begin
				if (!svBusy)
					con_nxt = servo_autotune_pkg::CON_BUSY; // RULE_11
			end
			servo_autotune_pkg::CON_BUSY: begin
				if (svDone)
					con_nxt = servo_autotune_pkg::CON_DONE; // RULE_11
				else if (svErr)
					con_nxt = servo_autotune_pkg::CON_ERR; // RULE_11
			end
			servo_autotune_pkg::CON_DONE, servo_autotune_pkg::CON_ERR: begin
				if (!keySync)
					con_nxt = servo_autotune_pkg::CON_IDLE;
			end
			default: con_nxt = servo_autotune_pkg::CON_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			con_r <= servo_autotune_pkg::CON_IDLE;
			hold_r <= '0;
			barCount <= '0;
			consState <= 3'h0;
		end else begin
			con_r <= con_nxt;
			hold_r <= hold_nxt;
			barCount <= bar_nxt;
			consState <= con_nxt;
		end
	end

	// ****************************************************************
	// interrupts
	// ****************************************************************
	always_comb begin
		irqSt_nxt = irqSt_r;
		if (wrAcc && address == `OFS_IRQ)
			irqSt_nxt = irqSt_r & ~writedata[`IRQ_W-1:0];
		// set wins over a clear in the same cycle
		irqSt_nxt = irqSt_nxt | ev;
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			irqSt_r <= '0;
			irq <= 1'b0;
		end else begin
			irqSt_r <= irqSt_nxt;
			irq <= |(irqSt_nxt & mask_nxt);
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	a_mode_latch_hold: assert property (@(posedge clk) disable iff (!rstN) // RULE_02
		(booted_r && !(drvSync && !drvPrev_r)) |=> $stable(modeLat_r))
		else $error("latched mode changed without enable edge");
	a_mode_latch_take: assert property (@(posedge clk) disable iff (!rstN) // RULE_02
		(booted_r && drvSync && !drvPrev_r) |=> modeLat_r == $past(modeSet_r))
		else $error("enable edge did not latch mode");
	a_tune_decode: assert property (@(posedge clk) disable iff (!rstN) // RULE_03
		booted_r |-> tuneOn == (modeLat_r != `MODE_OFF && modeLat_r != `MODE_RSVD))
		else $error("tune enable does not follow latched mode");
	a_filter_gate: assert property (@(posedge clk) disable iff (!rstN) // RULE_04
		filterOn |-> tuneOn && ctlMode_r == `CTL_HIPOS)
		else $error("adaptive filter active outside positioning mode");
	a_gain2_forced: assert property (@(posedge clk) disable iff (!rstN) // RULE_07
		tuneOn |=> par_r[`IDX_GAIN2] == `GAIN2_FIXED)
		else $error("second gain setup not forced");
	a_locked_write: assert property (@(posedge clk) disable iff (!rstN) // RULE_08
		(wrAcc && inTable && tuneOn) |=> irqSt_r[`IRQ_REJ])
		else $error("locked write not flagged");
	a_factory_default: assert property (@(posedge clk) disable iff (!rstN) // RULE_01
		(wrAcc && address == `OFS_CMD && writedata[`CMD_DEFAULT])
		|=> modeSet_r == `MODE_DEF)
		else $error("factory default did not set mode 1");
	a_periodic_save: assert property (@(posedge clk) disable iff (!rstN) // RULE_09
		(tuneOn && tmrHit) |=> pend_r || svBusy)
		else $error("periodic save not requested");
	a_boot_load: assert property (@(posedge clk) disable iff (!rstN) // RULE_10
		$rose(booted_r) |-> par_r[`IDX_INERTIA] == $past(nvmInitInertia))
		else $error("initial inertia not loaded");
	a_bar_limit: assert property (@(posedge clk) disable iff (!rstN) // RULE_11
		con_r == servo_autotune_pkg::CON_START |-> barCount == `BAR_MAX)
		else $error("save started before full bars");
	c_locked_reject: cover property (@(posedge clk) disable iff (!rstN)
		wrAcc && inTable && tuneOn);
	c_console_done: cover property (@(posedge clk) disable iff (!rstN)
		con_r == servo_autotune_pkg::CON_DONE);
	c_periodic_save: cover property (@(posedge clk) disable iff (!rstN)
		tuneOn && tmrHit);
endmodule : servo_autotune_control
`default_nettype wire

// file: bench/nvm_model.sv
// Purpose: behavioural nonvolatile memory behind the save port
// Assumes: one word per request, request held until acknowledged
// Notes: slow adds wait cycles; errOn makes the next acks report failure
`timescale 1ns/1ns
`default_nettype none
module nvm_model (
	input  wire logic        clk,
	input  wire logic        wrReq,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] data,
	input  wire logic        slow,
	input  wire logic        errOn,
	output logic             ack,
	output logic             err,
	output logic      [3:0]  lastAddr,
	output logic      [15:0] lastData,
	output int               nWords
);
	int waitCnt;
	initial begin
		ack = 1'b0;
		err = 1'b0;
		waitCnt = 0;
		nWords = 0;
		lastAddr = 4'h0;
		lastData = 16'h0000;
	end
	// error flag is only meaningful with ack, so it wanders otherwise
	always @(posedge clk) begin
		ack <= 1'b0;
		err <= ~err;
		if (wrReq && !ack) begin
			if (waitCnt >= (slow ? 5 : 0)) begin
				ack <= 1'b1;
				err <= errOn;
				waitCnt <= 0;
				lastAddr <= addr;
				lastData <= data;
				nWords <= nWords + 1;
			end else begin
				waitCnt <= waitCnt + 1;
			end
		end
	end
endmodule : nvm_model
`default_nettype wire

// file: bench/testbench.sv
// Purpose: self-checking bench for servo_autotune_control
// Assumes: SAVE_CYCLES 200 and HOLD_CYCLES 50 keep the run short
// Notes: registers only through the Avalon task; nvm values fixed
`timescale 1ns/1ns
`default_nettype none
`include "servo_autotune_params.svh"
module testbench;
	localparam logic [15:0] INIT_IN = 16'h00AB;
	localparam logic [15:0] INIT_FI = 16'h00CD;
	logic clk, arst_n, read, write, waitrequest, irq, driveEn, upKey;
	logic estValid, nvmWrReq, nvmAck, nvmErr, tuneOn, filterOn;
	logic slow, errOn, expTune;
	logic [7:0]  address;
	logic [31:0] writedata, readdata, q;
	logic [3:0]  estSel, nvmAddr, lastAddr;
	logic [15:0] estData, nvmData, lastData;
	logic [2:0]  barCount, consState, bars;
	int          nWords, failCount, nCompared, n, n0;
	servo_autotune_control #(.SAVE_CYCLES(64'd200), .HOLD_CYCLES(32'd50))
	i_servo_autotune_control (.clk(clk), .arst_n(arst_n),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .irq(irq), .driveEn(driveEn),
		.upKey(upKey), .estValid(estValid), .estSel(estSel),
		.estData(estData), .nvmInitInertia(INIT_IN),
		.nvmInitFilter(INIT_FI), .nvmWrReq(nvmWrReq), .nvmAddr(nvmAddr),
		.nvmData(nvmData), .nvmAck(nvmAck), .nvmErr(nvmErr),
		.tuneOn(tuneOn), .filterOn(filterOn), .barCount(barCount),
		.consState(consState));
	nvm_model i_nvm_model (.clk(clk), .wrReq(nvmWrReq), .addr(nvmAddr),
		.data(nvmData), .slow(slow), .errOn(errOn), .ack(nvmAck),
		.err(nvmErr), .lastAddr(lastAddr), .lastData(lastData),
		.nWords(nWords));
	// ********
	// tasks
	// ********
	task automatic end_sim();
		$display("compared %0d mismatches %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		nCompared++;
		if (g !== e) begin
			failCount++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask : cyc
	// the request stays put until the edge that sees waitrequest low
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		read <= ~wr;
		write <= wr;
		address <= a;
		writedata <= d;
		do begin
			@(posedge clk);
			k++;
		end while (waitrequest !== 1'b0);
		q = readdata;
		chk("bus latency", 32'h2, 32'(k));
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task automatic est(input logic [3:0] s, input logic [15:0] d);
		@(posedge clk);
		estValid <= 1'b1;
		estSel <= s;
		estData <= d;
		@(posedge clk);
		estValid <= 1'b0;
	endtask : est
	task automatic enEdge();
		driveEn <= 1'b0;
		cyc(6);
		driveEn <= 1'b1;
		cyc(8);
	endtask : enEdge
	// ********
	// scenarios
	// ********
	task automatic t_reset();
		bus(1'b0, `OFS_CTRL, 32'h0);
		chk("ctrl", 32'h00040201, q);
		bus(1'b0, 8'h40, 32'h0);
		chk("inertia", {16'h0, INIT_IN}, q);
		bus(1'b0, `OFS_PEND, 32'h0);
		chk("filter", {16'h0, INIT_FI}, q);
		bus(1'b0, `OFS_STAT, 32'h0);
		chk("stat", 32'h11, {27'h0, q[4:0]});
		bus(1'b0, 8'h80, 32'h0);
		chk("unmapped", 32'h0, q);
		bus(1'b1, `OFS_CTRL, 32'h00040200);
		bus(1'b1, `OFS_CMD, 32'h1);
		bus(1'b0, `OFS_CTRL, 32'h0);
		chk("default mode", 32'h1, {29'h0, q[2:0]});
		$display("reset test done");
	endtask : t_reset
	task automatic t_modes();
		logic [3:0] c;
		for (int m = 0; m < 8; m++) begin
			c = 4'(m % 3);
			driveEn <= 1'b0;
			bus(1'b1, `OFS_CTRL, {12'h0, `STIF_DEF, 4'h0, c, 5'h0, 3'(m)});
			cyc(8);
			chk("tune held", {31'h0, expTune}, {31'h0, tuneOn});
			expTune = (m != 0 && m != 7);
			driveEn <= 1'b1;
			cyc(8);
			chk("tune", {31'h0, expTune}, {31'h0, tuneOn});
			if (expTune) begin
				chk("filt", {31'h0, c == 4'h2}, {31'h0, filterOn});
			end
			bus(1'b0, `OFS_STAT, 32'h0);
			chk("stat mode", 32'(m), {29'h0, q[2:0]});
		end
		bus(1'b0, `OFS_IRQ, 32'h0);
		chk("latch event", 32'h1, {31'h0, q[`IRQ_LATCH]});
		bus(1'b1, `OFS_IRQ, 32'hF);
		$display("mode test done");
	endtask : t_modes
	task automatic t_lock();
		bus(1'b1, `OFS_PAR, 32'h55);
		bus(1'b1, 8'h44, 32'h0);
		bus(1'b0, `OFS_PAR, 32'h0);
		chk("par open", 32'h55, q);
		bus(1'b1, `OFS_CTRL, 32'h00040201);
		enEdge();
		bus(1'b1, `OFS_MASK, 32'h1);
		bus(1'b1, `OFS_PAR, 32'h66);
		bus(1'b0, `OFS_PAR, 32'h0);
		chk("par locked", 32'h55, q);
		cyc(2);
		chk("irq reject", 32'h1, {31'h0, irq});
		bus(1'b1, `OFS_IRQ, 32'h1);
		cyc(2);
		chk("irq clear", 32'h0, {31'h0, irq});
		est(4'h0, 16'h1234);
		est(4'h9, 16'h0007);
		est(4'h8, 16'h0321);
		bus(1'b0, `OFS_PAR, 32'h0);
		chk("par est", 32'h1234, q);
		bus(1'b0, 8'h44, 32'h0);
		chk("gain2", 32'h1, q);
		$display("lock test done");
	endtask : t_lock
	task automatic t_save();
		n0 = nWords;
		for (n = 0; n < 600 && !(nWords > n0 && lastAddr === 4'h8); n++)
			@(posedge clk);
		chk("save inertia", 32'h0321, {16'h0, lastData});
		n0 = nWords;
		for (n = 0; n < 40 && nWords == n0; n++)
			@(posedge clk);
		chk("save addr", 32'hA, {28'h0, lastAddr});
		chk("save filt", {16'h0, INIT_FI}, {16'h0, lastData});
		$display("save test done");
	endtask : t_save
	task automatic t_console();
		// tuning off so no periodic save muddies the save flags
		bus(1'b1, `OFS_CTRL, 32'h00040200);
		enEdge();
		chk("tune off", 32'h0, {31'h0, tuneOn});
		slow <= 1'b1;
		for (int e = 0; e < 2; e++) begin
			bus(1'b1, `OFS_IRQ, 32'hF);
			errOn <= 1'(e);
			upKey <= 1'b1;
			bars = 3'h0;
			for (n = 0; n < 600 && consState !== 3'(4 + e); n++) begin
				@(posedge clk);
				if (barCount > bars) bars = barCount;
			end
			chk("bars", 32'h5, {29'h0, bars});
			chk("console", 32'(4 + e), {29'h0, consState});
			bus(1'b0, `OFS_IRQ, 32'h0);
			chk("save flag", 32'(1 << e), {30'h0, q[2:1]});
			upKey <= 1'b0;
			cyc(10);
			chk("idle", 32'h0, {29'h0, consState});
		end
		errOn <= 1'b0;
		upKey <= 1'b1;
		cyc(20);
		upKey <= 1'b0;
		cyc(10);
		chk("early release", 32'h0, {29'h0, consState});
		$display("console test done");
	endtask : t_console
	// ********
	// run
	// ********
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#(20000 * 50);
		failCount++;
		$display("[ERR] watchdog expected finish seen timeout");
		end_sim();
	end
	initial begin
		{arst_n, read, write, driveEn, upKey, estValid} = 6'h0;
		{slow, errOn, expTune} = 3'h1;
		address = 8'h00;
		writedata = 32'h0;
		estSel = 4'h0;
		estData = 16'h0000;
		failCount = 0;
		nCompared = 0;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		cyc(3);
		t_reset();
		t_modes();
		t_lock();
		t_save();
		t_console();
		end_sim();
	end
endmodule : testbench
`default_nettype wire
